//--- fnb_defs.svh
// Summary of operation
// - Start code 1101 reads, 1110 writes
// - One clock target select field follows start
// - Transfer size field is one clock, 0000
// - Seven address clocks, 28 bits, high nibble first
// - Handshake codes: ready, short, long wait, error
// - Two data clocks, low nibble first
// - Identification mode: low address bit picks code
// - Lockout detection read reports lock on bit 0
// - Identification mode cleared when power returns
// - Write of F0 anywhere leaves identification mode
// - Reads allowed 100 us after power up
// - Writes ignored until 5 ms after power up
// - Unselected cycle keeps nibble outputs disabled
// - Codes also read at FBC0000 and FBC0001
`ifndef FNB_DEFS_SVH
`define FNB_DEFS_SVH
// Start codes
`define FNB_START_RD   4'hD
`define FNB_START_WR   4'hE
`define FNB_SIZE_BYTE  4'h0
// Handshake codes
`define FNB_SYNC_READY 4'h0
`define FNB_SYNC_SHORT 4'h5
`define FNB_SYNC_LONG  4'h6
`define FNB_SYNC_ERR   4'hA
// Field lengths minus one
`define FNB_ADDR_LAST  3'h6
`define FNB_TWO_LAST   3'h1
// Fixed identification addresses
`define FNB_ID_MFR_ADDR 28'hFBC0000
`define FNB_ID_DEV_ADDR 28'hFBC0001
// Command sequence
`define FNB_CMD_A1     15'h5555
`define FNB_CMD_A2     15'h2AAA
`define FNB_CMD_D1     8'hAA
`define FNB_CMD_D2     8'h55
`define FNB_CMD_ENTER  8'h90
`define FNB_CMD_EXIT   8'hF0
// Power-up hold-off
`define FNB_CLK_MHZ    25
`define FNB_PU_RD_US   100
`define FNB_PU_WR_MS   5
`define FNB_PU_RD_CYC  (`FNB_PU_RD_US * `FNB_CLK_MHZ)
`define FNB_PU_WR_CYC  (`FNB_PU_WR_MS * 1000 * `FNB_CLK_MHZ)
// Register offsets
`define FNB_REG_CTRL   8'h00
`define FNB_REG_STAT   8'h04
`define FNB_REG_ISTAT  8'h08
`define FNB_REG_IMASK  8'h0C
// Control fields and reset value
`define FNB_CTRL_EN    0
`define FNB_CTRL_ID_LO 1
`define FNB_CTRL_RST   5'h01
`endif

//--- fnb_pkg.sv
package fnb_pkg;
  // Cycle sequencer states
  typedef enum logic [3:0] {
    FNB_IDLE  = 4'h0,
    FNB_TSEL  = 4'h1,
    FNB_ADDR  = 4'h2,
    FNB_SIZE  = 4'h3,
    FNB_WDATA = 4'h4,
    FNB_TARI  = 4'h5,
    FNB_SYNC  = 4'h6,
    FNB_RDATA = 4'h7,
    FNB_TARO  = 4'h8
  } fnb_state_e;

  // Request toward the flash array
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [17:0] addr;
    logic [7:0]  wdata;
  } fnb_mem_req_s;

  // Whole state of the target
  typedef struct packed {
    fnb_state_e   st;
    logic [2:0]   cnt;
    logic         wr;
    logic         sel;
    logic [27:0]  addr;
    logic [7:0]   data;
    logic [3:0]   nib_o;
    logic         nib_oe_n;
    logic         id_mode;
    logic [1:0]   cmd_stg;
    logic [16:0]  pu_cnt;
    fnb_mem_req_s mem;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [4:0]   ctrl;
    logic [3:0]   ist;
    logic [3:0]   imask;
    logic         irq;
  } fnb_state_s;
endpackage : fnb_pkg

//--- fnb_target.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "fnb_defs.svh"

module fnb_target import fnb_pkg::*; #(
  parameter logic [16:0] WR_WAIT_CYC = 17'(`FNB_PU_WR_CYC),
  parameter logic [7:0]  MFR_CODE    = 8'h5A,  // Arbitrary value
  parameter logic [7:0]  DEV_CODE    = 8'hA5   // Arbitrary value
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  output logic              irq,
  input  wire logic         cycle_framing_n,
  input  wire logic [3:0]   nibble_bus_i,
  output logic [3:0]        nibble_bus_o,
  output logic              nibble_bus_oe_n,
  output fnb_mem_req_s      mem_req,
  input  wire logic [7:0]   mem_rdata,
  input  wire logic         boot_lock
);

  localparam logic [16:0] RD_WAIT_CYC = 17'(`FNB_PU_RD_CYC);

  // Counter width and ordering must hold both hold-off counts
  if (WR_WAIT_CYC < RD_WAIT_CYC) begin : g_chk
    $error("fnb_target: write hold-off shorter than read hold-off");
  end

  fnb_state_s s_ff;     // Registered state
  fnb_state_s nxt_s;    // Next state

  // Read data source: fixed codes, identification mode, or array
  function automatic logic [7:0] rd_value(input logic [27:0] a,
                                          input logic        idm,
                                          input logic        lock,
                                          input logic [7:0]  arr);
    if (a == `FNB_ID_MFR_ADDR)
      rd_value = MFR_CODE;
    else if (a == `FNB_ID_DEV_ADDR)
      rd_value = DEV_CODE;
    else if (idm && a[17:1] == 17'h00000)
      rd_value = a[0] ? DEV_CODE : MFR_CODE;
    else if (idm)
      rd_value = {7'h00, lock};
    else
      rd_value = arr;
  endfunction : rd_value

  // Register read mux
  function automatic logic [31:0] reg_rd(input fnb_state_s s,
                                         input logic [7:0] a);
    case (a)
      `FNB_REG_CTRL:  reg_rd = {27'h0, s.ctrl};
      `FNB_REG_STAT:  reg_rd = {28'h0, s.id_mode,
                                s.pu_cnt >= WR_WAIT_CYC,
                                s.pu_cnt >= RD_WAIT_CYC,
                                s.st != FNB_IDLE};
      `FNB_REG_ISTAT: reg_rd = {28'h0, s.ist};
      `FNB_REG_IMASK: reg_rd = {28'h0, s.imask};
      default:        reg_rd = 32'h0;
    endcase
  endfunction : reg_rd

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `FNB_REG_CTRL) || (a == `FNB_REG_STAT) ||
              (a == `FNB_REG_ISTAT) || (a == `FNB_REG_IMASK);
  endfunction : reg_hit

  // Next state of sequencer, command tracker and register file
  always_comb begin
    logic       rd_ok;
    logic       wr_ok;
    logic       bus_wr;
    logic [3:0] ev;
    logic [7:0] rv;
    nxt_s  = s_ff;
    rd_ok  = s_ff.pu_cnt >= RD_WAIT_CYC;
    wr_ok  = s_ff.pu_cnt >= WR_WAIT_CYC;
    bus_wr = psel && penable && s_ff.pready && pwrite;
    ev     = 4'h0;
    rv     = rd_value(s_ff.addr, s_ff.id_mode, boot_lock, mem_rdata);

    // Power-up hold-off counter, saturates
    if (!wr_ok)
      nxt_s.pu_cnt = s_ff.pu_cnt + 17'h00001;

    // Array strobes last one cycle
    nxt_s.mem.rd = 1'b0;
    nxt_s.mem.wr = 1'b0;

    case (s_ff.st)
      // Wait for framing with a valid start code
      FNB_IDLE: begin
        nxt_s.nib_oe_n = 1'b1;
      end
      // Target select decides whether we answer at all
      FNB_TSEL: begin
        nxt_s.sel = s_ff.ctrl[`FNB_CTRL_EN] &&
                    nibble_bus_i == s_ff.ctrl[`FNB_CTRL_ID_LO +: 4];
        nxt_s.st  = FNB_ADDR;
        nxt_s.cnt = 3'h0;
      end
      // Address, most significant nibble first
      FNB_ADDR: begin
        nxt_s.addr = {s_ff.addr[23:0], nibble_bus_i};
        nxt_s.cnt  = s_ff.cnt + 3'h1;
        if (s_ff.cnt == `FNB_ADDR_LAST)
          nxt_s.st = FNB_SIZE;
      end
      // Only single byte size is served
      FNB_SIZE: begin
        if (nibble_bus_i != `FNB_SIZE_BYTE)
          nxt_s.sel = 1'b0;
        nxt_s.st  = s_ff.wr ? FNB_WDATA : FNB_TARI;
        nxt_s.cnt = 3'h0;
      end
      // Write data, low nibble first
      FNB_WDATA: begin
        if (s_ff.cnt == 3'h0) begin
          nxt_s.data[3:0] = nibble_bus_i;
          nxt_s.cnt       = 3'h1;
        end else begin
          nxt_s.data[7:4] = nibble_bus_i;
          nxt_s.st        = FNB_TARI;
          nxt_s.cnt       = 3'h0;
        end
      end
      // Turnaround toward the target, bus left floating
      FNB_TARI: begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
        if (s_ff.cnt == `FNB_TWO_LAST) begin
          nxt_s.st       = FNB_SYNC;
          nxt_s.cnt      = 3'h0;
          nxt_s.nib_oe_n = !s_ff.sel;
          if (s_ff.wr) begin
            nxt_s.nib_o = `FNB_SYNC_READY;
            if (s_ff.sel && wr_ok) begin
              nxt_s.mem.wr    = 1'b1;
              nxt_s.mem.addr  = s_ff.addr[17:0];
              nxt_s.mem.wdata = s_ff.data;
              // Command tracker for identification entry
              if (s_ff.data == `FNB_CMD_EXIT) begin
                nxt_s.id_mode = 1'b0;
                nxt_s.cmd_stg = 2'h0;
              end else if (s_ff.cmd_stg == 2'h0 &&
                           s_ff.addr[14:0] == `FNB_CMD_A1 &&
                           s_ff.data == `FNB_CMD_D1)
                nxt_s.cmd_stg = 2'h1;
              else if (s_ff.cmd_stg == 2'h1 &&
                       s_ff.addr[14:0] == `FNB_CMD_A2 &&
                       s_ff.data == `FNB_CMD_D2)
                nxt_s.cmd_stg = 2'h2;
              else if (s_ff.cmd_stg == 2'h2 &&
                       s_ff.addr[14:0] == `FNB_CMD_A1 &&
                       s_ff.data == `FNB_CMD_ENTER) begin
                nxt_s.id_mode = 1'b1;
                nxt_s.cmd_stg = 2'h0;
              end else
                nxt_s.cmd_stg = 2'h0;
            end
            if (s_ff.sel && !wr_ok)
              ev[3] = 1'b1;
          end else begin
            // One short wait while the array answers
            nxt_s.nib_o    = `FNB_SYNC_SHORT;
            nxt_s.mem.rd   = s_ff.sel && rd_ok;
            nxt_s.mem.addr = s_ff.addr[17:0];
          end
        end
      end
      // Handshake field driven by the target
      FNB_SYNC: begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
        if (s_ff.wr) begin
          nxt_s.st       = FNB_TARO;
          nxt_s.cnt      = 3'h0;
          nxt_s.nib_oe_n = 1'b1;
        end else if (s_ff.cnt == 3'h0) begin
          nxt_s.nib_o = rd_ok ? `FNB_SYNC_READY : `FNB_SYNC_ERR;
        end else begin
          nxt_s.data  = rd_ok ? rv : 8'hFF;
          nxt_s.nib_o = rd_ok ? rv[3:0] : 4'hF;
          nxt_s.st    = FNB_RDATA;
          nxt_s.cnt   = 3'h0;
        end
      end
      // Read data, low nibble was driven on entry
      FNB_RDATA: begin
        if (s_ff.cnt == 3'h0) begin
          nxt_s.nib_o = s_ff.data[7:4];
          nxt_s.cnt   = 3'h1;
        end else begin
          nxt_s.st       = FNB_TARO;
          nxt_s.cnt      = 3'h0;
          nxt_s.nib_oe_n = 1'b1;
        end
      end
      // Turnaround back to the host, then report the cycle
      FNB_TARO: begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
        if (s_ff.cnt == `FNB_TWO_LAST) begin
          nxt_s.st = FNB_IDLE;
          ev[0]    = s_ff.sel && !s_ff.wr;
          ev[1]    = s_ff.sel && s_ff.wr;
          ev[2]    = s_ff.sel && !s_ff.wr && !rd_ok;
        end
      end
      default: begin
        nxt_s.st       = FNB_IDLE;
        nxt_s.nib_oe_n = 1'b1;
      end
    endcase

    // Framing with a start code begins a cycle from any state
    if (!cycle_framing_n) begin
      nxt_s.nib_oe_n = 1'b1;
      nxt_s.sel      = 1'b0;
      if (nibble_bus_i == `FNB_START_RD ||
          nibble_bus_i == `FNB_START_WR) begin
        nxt_s.wr = nibble_bus_i == `FNB_START_WR;
        nxt_s.st = FNB_TSEL;
      end else
        nxt_s.st = FNB_IDLE;
    end

    // APB: data prepared in setup, pready in the access cycle
    nxt_s.pready  = psel && !penable;
    nxt_s.pslverr = psel && !penable && !reg_hit(paddr);
    if (psel && !penable)
      nxt_s.prdata = reg_rd(s_ff, paddr);
    if (bus_wr && paddr == `FNB_REG_CTRL)
      nxt_s.ctrl = pwdata[4:0];
    if (bus_wr && paddr == `FNB_REG_IMASK)
      nxt_s.imask = pwdata[3:0];
    // Write one to clear; a new event wins over the clear
    if (bus_wr && paddr == `FNB_REG_ISTAT)
      nxt_s.ist = s_ff.ist & ~pwdata[3:0];
    nxt_s.ist = nxt_s.ist | ev;
    nxt_s.irq = |(nxt_s.ist & nxt_s.imask);
  end

  // State register; reset stands for loss of power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff          <= '0;
      s_ff.st       <= FNB_IDLE;
      s_ff.nib_oe_n <= 1'b1;
      s_ff.id_mode  <= 1'b0;
      s_ff.ctrl     <= `FNB_CTRL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign pready          = s_ff.pready;
  assign pslverr         = s_ff.pslverr;
  assign prdata          = s_ff.prdata;
  assign irq             = s_ff.irq;
  assign nibble_bus_o    = s_ff.nib_o;
  assign nibble_bus_oe_n = s_ff.nib_oe_n;
  assign mem_req         = s_ff.mem;

endmodule : fnb_target

//--- fnb_target_props.sv
`timescale 1ns/1ps
`include "fnb_defs.svh"
// Port watcher for the nibble bus target; framed cycles are named sequences
module fnb_target_props import fnb_pkg::*; #(
  parameter logic [16:0] WR_WAIT_CYC = 17'(`FNB_PU_WR_CYC)
) (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [31:0]  prdata,
  input wire logic         irq,
  input wire logic         cycle_framing_n,
  input wire logic [3:0]   nibble_bus_i,
  input wire logic [3:0]   nibble_bus_o,
  input wire logic         nibble_bus_oe_n,
  input wire fnb_mem_req_s mem_req,
  input wire logic [7:0]   mem_rdata,
  input wire logic         boot_lock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since reset; saturates so the hold-off checks never wrap
  logic [16:0] up_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_cnt_ff <= 17'h00000;
    else if (up_cnt_ff != 17'h1FFFF) up_cnt_ff <= up_cnt_ff + 17'h00001;
  end
  // Start clocks and the host-driven headers up to the first turnaround end
  sequence rd_go; !cycle_framing_n && nibble_bus_i == `FNB_START_RD; endsequence
  sequence wr_go; !cycle_framing_n && nibble_bus_i == `FNB_START_WR; endsequence
  sequence rd_hdr; rd_go ##1 cycle_framing_n [*8] ##1 cycle_framing_n [*3]; endsequence
  sequence wr_hdr; wr_go ##1 cycle_framing_n [*8] ##1 cycle_framing_n [*5]; endsequence
  rd_float_a: assert property (rd_go |=> nibble_bus_oe_n [*8] ##1 nibble_bus_oe_n [*3])
    else $error("read header clocks driven by target");
  wr_float_a: assert property (wr_go |=> nibble_bus_oe_n [*8] ##1 nibble_bus_oe_n [*5])
    else $error("write header clocks driven by target");
  rd_sync_a: assert property (rd_hdr ##1 !nibble_bus_oe_n |-> nibble_bus_o == `FNB_SYNC_SHORT
    ##1 (!nibble_bus_oe_n && (nibble_bus_o == `FNB_SYNC_READY || nibble_bus_o == `FNB_SYNC_ERR)))
    else $error("read handshake codes wrong");
  rd_data_a: assert property (rd_hdr ##1 !nibble_bus_oe_n ##1 !nibble_bus_oe_n
    |=> !nibble_bus_oe_n [*2] ##1 nibble_bus_oe_n [*2])
    else $error("read data or closing turnaround wrong");
  wr_sync_a: assert property (wr_hdr ##1 !nibble_bus_oe_n
    |-> nibble_bus_o == `FNB_SYNC_READY ##1 nibble_bus_oe_n [*2])
    else $error("write handshake or turnaround wrong");
  rd_early_a: assert property (rd_hdr ##1 !nibble_bus_oe_n
    ##1 (nibble_bus_o == `FNB_SYNC_READY) |-> up_cnt_ff >= `FNB_PU_RD_CYC)
    else $error("read ready before hold-off");
  mem_rd_a: assert property ($rose(mem_req.rd)
    |-> !nibble_bus_oe_n && nibble_bus_o == `FNB_SYNC_SHORT ##1 !mem_req.rd)
    else $error("array read not in short wait clock");
  mem_wr_a: assert property (mem_req.wr |-> !nibble_bus_oe_n &&
    nibble_bus_o == `FNB_SYNC_READY && up_cnt_ff >= WR_WAIT_CYC)
    else $error("array write early or outside handshake");
  frame_float_a: assert property (!nibble_bus_oe_n |-> cycle_framing_n)
    else $error("target drives in start clock");
  apb_ready_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside single access cycle");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : fnb_target_props

bind fnb_target fnb_target_props #(.WR_WAIT_CYC(WR_WAIT_CYC)) u_fnb_target_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .irq(irq), .cycle_framing_n(cycle_framing_n), .nibble_bus_i(nibble_bus_i),
  .nibble_bus_o(nibble_bus_o), .nibble_bus_oe_n(nibble_bus_oe_n), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .boot_lock(boot_lock));

//--- fnb_host.sv
`timescale 1ns/1ps
// Host controller model: frames cycles and collects the target's answer
module fnb_host (
  input  wire logic       pclk,
  input  wire logic [3:0] bus,      // Resolved wire level
  output logic            frame_n,  // Framing, active low
  output logic [3:0]      nib,      // Value the host drives
  output logic            drv,      // Host drives the wire
  output logic            res_v,    // One-clock result strobe
  output logic [11:0]     res_d     // Handshake code and data byte
);
  initial begin
    frame_n = 1'b1;
    nib = 4'h0;
    drv = 1'b0;
    res_v = 1'b0;
    res_d = 12'h000;
  end
  // Strobe lasts one clock
  always @(posedge pclk) if (res_v) res_v <= 1'b0;
  // One framed cycle; wire sampled before this edge's updates land
  task automatic cyc(input bit wr, input logic [3:0] sel, input logic [3:0] sz,
                     input logic [27:0] a, input logic [7:0] d);
    logic [3:0] s;
    int         n;
    @(posedge pclk);
    frame_n <= 1'b0;
    drv <= 1'b1;
    nib <= wr ? 4'hE : 4'hD;
    @(posedge pclk);
    frame_n <= 1'b1;
    nib <= sel;
    for (int i = 6; i >= 0; i--) begin
      @(posedge pclk);
      nib <= a[i*4 +: 4];
    end
    @(posedge pclk);
    nib <= sz;
    if (wr) begin
      @(posedge pclk);
      nib <= d[3:0];
      @(posedge pclk);
      nib <= d[7:4];
    end
    @(posedge pclk);
    drv <= 1'b0;
    repeat (2) @(posedge pclk);
    n = 0;
    // Wait states end on any code but short or long wait; bounded
    do begin
      @(posedge pclk);
      s = bus;
      n++;
    end while ((s == 4'h5 || s == 4'h6) && n < 40);
    res_d <= {s, 8'h00};
    if (!wr) begin
      @(posedge pclk);
      res_d[3:0] <= bus;
      @(posedge pclk);
      res_d[7:4] <= bus;
    end
    @(posedge pclk);
    res_v <= 1'b1;
  endtask : cyc
endmodule : fnb_host

//--- tb_top.sv
`timescale 1ns/1ps
`include "fnb_defs.svh"
module tb_top import fnb_pkg::*;;
  localparam logic [16:0] WR_WAIT = 17'h00BB8;  // Short hold-off, 3000 cycles
  localparam logic [7:0]  MFR     = 8'h5A;      // Arbitrary value
  localparam logic [7:0]  DEV     = 8'hA5;      // Arbitrary value
  logic         pclk = 1'b0;
  logic         presetn, psel, penable, pwrite, boot_lock, pready, pslverr, irq;
  logic         frame_n, oe_n, h_drv, h_v, a_v;
  logic [7:0]   paddr, mem_rdata;
  logic [31:0]  pwdata, prdata, rnd;
  logic [3:0]   nib_o, h_nib;
  logic [11:0]  h_d;
  logic [39:0]  a_d, exp_q[$];
  fnb_mem_req_s mem_req;
  int           bad_count = 0, cmp_count = 0, cyc_cnt = 0;
  // Pulled up when neither side drives
  wire  [3:0]   nib_w = !oe_n ? nib_o : h_drv ? h_nib : 4'hF;
  fnb_target #(.WR_WAIT_CYC(WR_WAIT), .MFR_CODE(MFR), .DEV_CODE(DEV)) u_fnb_target (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .irq(irq), .cycle_framing_n(frame_n), .nibble_bus_i(nib_w), .nibble_bus_o(nib_o),
    .nibble_bus_oe_n(oe_n), .mem_req(mem_req), .mem_rdata(mem_rdata), .boot_lock(boot_lock));
  fnb_host u_fnb_host (.pclk(pclk), .bus(nib_w), .frame_n(frame_n), .nib(h_nib),
    .drv(h_drv), .res_v(h_v), .res_d(h_d));
  always #20 pclk = ~pclk;
  // Array model: data ready one edge after the read pulse
  always @(posedge pclk) if (mem_req.rd) mem_rdata <= mem_req.addr[7:0] ^ 8'h3C;
  always @(posedge pclk) if (a_v) a_v <= 1'b0;
  // Hang guard
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [39:0] got);
    logic [39:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 40'hX;
    cmp_count++;
    if (got !== e) begin
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
      bad_count++;
    end
  endtask : chk
  // Results are taken in the order the drivers noted them
  always @(posedge pclk) begin
    if (a_v) chk(a_d);
    if (h_v) chk({28'h0, h_d});
    if (mem_req.wr) chk({4'hC, 10'h0, mem_req.addr, mem_req.wdata});
  end
  // Request held until ready is seen, then released
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    a_d <= {4'hA, 2'b00, irq, pslverr, prdata};
    a_v <= !wr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Register read; idle clocks first so pending events settle
  task automatic ra(input logic [7:0] a, input logic [33:0] e);
    repeat (2) @(posedge pclk);
    exp_q.push_back({4'hA, 2'b00, e});
    apb(1'b0, a, 32'h0);
  endtask : ra
  task automatic nr(input logic [3:0] sel, input logic [27:0] a, input logic [11:0] e);
    exp_q.push_back({28'h0, e});
    u_fnb_host.cyc(1'b0, sel, 4'h0, a, 8'h00);
  endtask : nr
  task automatic nw(input logic [3:0] sel, sz, input logic [27:0] a, input logic [7:0] d,
                    input bit acc, input logic [3:0] sy);
    if (acc) exp_q.push_back({4'hC, 10'h0, a[17:0], d});
    exp_q.push_back({28'h0, sy, 8'h00});
    u_fnb_host.cyc(1'b1, sel, sz, a, d);
  endtask : nw
  task automatic idin();
    nw(4'h0, 4'h0, 28'h5555, 8'hAA, 1'b1, 4'h0);
    nw(4'h0, 4'h0, 28'h2AAA, 8'h55, 1'b1, 4'h0);
    nw(4'h0, 4'h0, 28'h5555, 8'h90, 1'b1, 4'h0);
  endtask : idin
  task automatic end_sim();
    if (exp_q.size() != 0) bad_count++;
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, boot_lock, a_v} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_rdata = 8'h00;
    a_d = 40'h0;
    rnd = xs(32'h4146);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    ra(`FNB_REG_CTRL, 34'h1);
    ra(`FNB_REG_STAT, 34'h0);
    ra(8'h10, {2'b01, 32'h0});
    nr(4'h0, {4'h0, rnd[23:0]}, 12'hAFF);
    apb(1'b1, `FNB_REG_ISTAT, 32'hF);
    nw(4'h0, 4'h0, rnd[27:0], rnd[7:0], 1'b0, 4'h0);
    ra(`FNB_REG_ISTAT, 34'hA);
    apb(1'b1, `FNB_REG_IMASK, 32'h8);
    ra(`FNB_REG_IMASK, {2'b10, 32'h8});
    apb(1'b1, `FNB_REG_ISTAT, 32'h8);
    ra(`FNB_REG_ISTAT, 34'h2);
    apb(1'b1, `FNB_REG_IMASK, 32'h0);
    repeat (3000) @(posedge pclk);
    ra(`FNB_REG_STAT, 34'h6);
    rnd = xs(rnd);
    nr(4'h0, {4'h0, rnd[23:0]}, {4'h0, rnd[7:0] ^ 8'h3C});
    nw(4'h0, 4'h0, {4'h0, rnd[31:8]}, rnd[7:0], 1'b1, 4'h0);
    idin();
    ra(`FNB_REG_STAT, 34'hE);
    boot_lock <= rnd[0];
    nr(4'h0, 28'h0, {4'h0, MFR});
    nr(4'h0, 28'h1, {4'h0, DEV});
    nr(4'h0, 28'h2, {11'h0, rnd[0]});
    nw(4'h0, 4'h0, {4'h0, rnd[23:0]}, 8'hF0, 1'b1, 4'h0);
    nr(4'h0, 28'h0, 12'h03C);
    nr(4'h0, 28'hFBC0001, {4'h0, DEV});
    apb(1'b1, `FNB_REG_CTRL, 32'h7);
    nr(4'h3, 28'h0, 12'h03C);
    nr(4'h0, 28'h0, 12'hFFF);
    apb(1'b1, `FNB_REG_CTRL, 32'h1);
    nw(4'h0, 4'h1, 28'h0, 8'h00, 1'b0, 4'hF);
    idin();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2600) @(posedge pclk);
    nr(4'h0, 28'h0, 12'h03C);
    repeat (4) @(posedge pclk);
    end_sim();
  end
endmodule : tb_top
